/* src/plld_defines.svh */
// Latch addresses, field positions, limits and reset words of the divider block
`ifndef PLLD_DEFINES_SVH
`define PLLD_DEFINES_SVH
`define PLLD_WORD_W 24
`define PLLD_ADDR_RF_R 2'h0
`define PLLD_ADDR_RF_N 2'h1
`define PLLD_ADDR_IF_R 2'h2
`define PLLD_ADDR_IF_N 2'h3
`define PLLD_R_LSB 2
`define PLLD_R_MSB 16
`define PLLD_REF_SEL_BIT 23
`define PLLD_FRAC_LSB 2
`define PLLD_FRAC_MSB 5
`define PLLD_RF_A_LSB 6
`define PLLD_RF_A_MSB 7
`define PLLD_RF_B_LSB 8
`define PLLD_RF_B_MSB 9
`define PLLD_RF_PRESC_BIT 9
`define PLLD_RF_C_LSB 10
`define PLLD_RF_C_MSB 20
`define PLLD_FRAC_EN_BIT 21
`define PLLD_MOD15_BIT 22
`define PLLD_IF_A_LSB 2
`define PLLD_IF_A_MSB 4
`define PLLD_IF_B_LSB 5
`define PLLD_IF_B_MSB 16
`define PLLD_R_MIN 15'h0003
`define PLLD_RF_C_MIN 11'h003
`define PLLD_RF_FRAC_MIN_LO 15'h0028
`define PLLD_RF_FRAC_MIN_HI 15'h0050
`define PLLD_IF_N_MIN 15'h0038
`define PLLD_MOD_15 5'h0F
`define PLLD_MOD_16 5'h10
`define PLLD_RST_RF_R 24'h000028
`define PLLD_RST_RF_N 24'h001400
`define PLLD_RST_IF_R 24'h000028
`define PLLD_RST_IF_N 24'h0000E0
`endif

/* src/plld_pkg.sv */
// State types of the divider block
package plld_pkg;
  typedef struct packed {
    logic [18:0] cnt;
    logic [18:0] div;
    logic pulse;
  } plld_div_st_t;

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] lvl;
    logic [23:0] shift;
    logic [23:0] rf_r;
    logic [23:0] rf_n;
    logic [23:0] if_r;
    logic [23:0] if_n;
    logic [3:0] acc;
    logic carry;
    logic invalid;
  } plld_top_st_t;
endpackage : plld_pkg

/* src/plld_div.sv */
// Programmable event divider with reload-boundary capture of its divide value
`timescale 1ns/10ps
`default_nettype none
module plld_div #(
  parameter int W = 15
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic clr,
  input wire logic tick,
  input wire logic [W-1:0] div_val,
  output logic pulse
);
  plld_pkg::plld_div_st_t q;
  plld_pkg::plld_div_st_t d;

  if (W < 2 || W > 19) begin : g_bad_width
    $error("plld_div width must lie in 2..19");
  end

  always_comb begin
    d = q;
    d.pulse = 1'b0;
    if (clr) begin
      // Armed at zero so the first tick after release starts a period
      d.cnt = '0;
    end else if (tick) begin
      if (q.cnt == '0) begin
        d.pulse = 1'b1;
        d.div = 19'(div_val);
        d.cnt = (div_val <= W'(1)) ? '0 : 19'(div_val - W'(1));
      end else begin
        d.cnt = q.cnt - 19'h00001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign pulse = q.pulse;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_pulse_cause: assert property (clk_en && pulse |-> $past(tick) && !$past(clr))
    else $error("divider pulse without a tick");
  a_count_down: assert property (clk_en && tick && !clr && q.cnt != '0 |=> q.cnt == $past(q.cnt) - 19'h00001)
    else $error("divider count did not step down");
endmodule : plld_div
`default_nettype wire

/* src/plld_dividers.sv */
// Reference and feedback dividers of a dual synthesizer with serial latch loading
`timescale 1ns/10ps
`default_nettype none
`include "plld_defines.svh"
module plld_dividers (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_strobe,
  input wire logic osc_if_in,
  input wire logic osc_rf_in,
  input wire logic rf_vco_in,
  input wire logic if_vco_in,
  input wire logic rf_pwr_dn,
  input wire logic if_pwr_dn,
  output logic rf_comparison_reference,
  output logic rf_feedback_divided,
  output logic if_comparison_reference,
  output logic if_feedback_divided,
  output logic ref_path_select,
  output logic rf_frac_carry,
  output logic cfg_invalid
);
  localparam int NPIN = 7;
  localparam int P_SCLK = 0;
  localparam int P_SDATA = 1;
  localparam int P_LE = 2;
  localparam int P_OSC_IF = 3;
  localparam int P_OSC_RF = 4;
  localparam int P_RF_VCO = 5;
  localparam int P_IF_VCO = 6;

  localparam plld_pkg::plld_top_st_t RST_ST = '{
    rf_r: `PLLD_RST_RF_R,
    rf_n: `PLLD_RST_RF_N,
    if_r: `PLLD_RST_IF_R,
    if_n: `PLLD_RST_IF_N,
    default: '0
  };

  plld_pkg::plld_top_st_t q;
  plld_pkg::plld_top_st_t d;
  logic [6:0] rise;
  logic [4:0] acc_sum;
  logic [4:0] acc_mod;
  logic frac_en;
  logic rf_r_tick;
  logic [14:0] rf_int;
  logic [18:0] rf_div_val;
  logic [14:0] if_div_val;
  logic bad;

  // Integer RF divide from C, B and A for the selected prescaler set
  function automatic logic [14:0] rf_int_div(input logic [23:0] w);
    logic [10:0] c;
    logic [1:0] b;
    logic [1:0] a;
    c = w[`PLLD_RF_C_MSB:`PLLD_RF_C_LSB];
    b = w[`PLLD_RF_B_MSB:`PLLD_RF_B_LSB];
    a = w[`PLLD_RF_A_MSB:`PLLD_RF_A_LSB];
    if (w[`PLLD_RF_PRESC_BIT]) begin
      rf_int_div = {c, 4'h0} + {11'h000, b, 2'h0} + {13'h0000, a};
    end else begin
      // The upper B bit is the prescaler select and does not count here
      rf_int_div = {1'b0, c, 3'h0} + {12'h000, b[0], 2'h0} + {13'h0000, a};
    end
  endfunction : rf_int_div

  function automatic logic [14:0] r_div(input logic [23:0] w);
    r_div = w[`PLLD_R_MSB:`PLLD_R_LSB];
  endfunction : r_div

  function automatic logic [3:0] frac_num(input logic [23:0] w);
    frac_num = w[`PLLD_FRAC_MSB:`PLLD_FRAC_LSB];
  endfunction : frac_num

  assign frac_en = q.rf_n[`PLLD_FRAC_EN_BIT];
  assign rf_int = rf_int_div(q.rf_n);
  assign acc_sum = {1'b0, q.acc} + {1'b0, frac_num(q.rf_n)};
  assign acc_mod = q.rf_n[`PLLD_MOD15_BIT] ? `PLLD_MOD_15 : `PLLD_MOD_16;

  // Fractional: integer plus pending swallow; integer mode uses all 19 bits
  assign rf_div_val = frac_en ? ({4'h0, rf_int} + {18'h00000, q.carry})
                              : {rf_int, frac_num(q.rf_n)};
  assign if_div_val = {q.if_n[`PLLD_IF_B_MSB:`PLLD_IF_B_LSB], 3'h0}
                    + {12'h000, q.if_n[`PLLD_IF_A_MSB:`PLLD_IF_A_LSB]};

  // Shared path takes the IF oscillator for the RF reference counter too
  assign rf_r_tick = q.if_r[`PLLD_REF_SEL_BIT] ? rise[P_OSC_IF] : rise[P_OSC_RF];

  always_comb begin
    bad = 1'b0;
    if (q.rf_n[`PLLD_RF_C_MSB:`PLLD_RF_C_LSB] < `PLLD_RF_C_MIN) begin
      bad = 1'b1;
    end
    if (frac_en && rf_int < (q.rf_n[`PLLD_RF_PRESC_BIT] ? `PLLD_RF_FRAC_MIN_HI
                                                         : `PLLD_RF_FRAC_MIN_LO)) begin
      bad = 1'b1;
    end
    if (r_div(q.rf_r) < `PLLD_R_MIN || r_div(q.if_r) < `PLLD_R_MIN) begin
      bad = 1'b1;
    end
    if (if_div_val < `PLLD_IF_N_MIN
        || q.if_n[`PLLD_IF_B_MSB:`PLLD_IF_B_LSB] < 12'(q.if_n[`PLLD_IF_A_MSB:`PLLD_IF_A_LSB])) begin
      bad = 1'b1;
    end
  end

  always_comb begin
    d = q;
    rise = '0;
    d.s1 = {if_vco_in, rf_vco_in, osc_rf_in, osc_if_in, latch_strobe, ser_data, ser_clk};
    d.s2 = q.s1;
    d.s3 = q.s2;
    // A pin change counts once the second and third stages agree
    for (int i = 0; i < NPIN; i++) begin
      if (q.s2[i] == q.s3[i] && q.s2[i] != q.lvl[i]) begin
        d.lvl[i] = q.s2[i];
        rise[i] = q.s2[i];
      end
    end
    if (rise[P_SCLK]) begin
      d.shift = {q.shift[22:0], q.lvl[P_SDATA]};
    end
    if (rise[P_LE]) begin
      unique case (q.shift[1:0])
        `PLLD_ADDR_RF_R: d.rf_r = q.shift;
        `PLLD_ADDR_RF_N: d.rf_n = q.shift;
        `PLLD_ADDR_IF_R: d.if_r = q.shift;
        `PLLD_ADDR_IF_N: d.if_n = q.shift;
      endcase
    end
    // Accumulator steps once per feedback period, after that period's reload
    if (rf_pwr_dn) begin
      d.acc = '0;
      d.carry = 1'b0;
    end else if (!frac_en) begin
      d.carry = 1'b0;
    end else if (rf_feedback_divided) begin
      if (acc_sum >= acc_mod) begin
        d.acc = 4'(acc_sum - acc_mod);
        d.carry = 1'b1;
      end else begin
        d.acc = acc_sum[3:0];
        d.carry = 1'b0;
      end
    end
    d.invalid = bad;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= RST_ST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // Each divider samples its value only when it reloads
  plld_div #(.W(15)) u_rf_ref (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .clr(rf_pwr_dn),
    .tick(rf_r_tick),
    .div_val(r_div(q.rf_r)),
    .pulse(rf_comparison_reference)
  );

  plld_div #(.W(15)) u_if_ref (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .clr(if_pwr_dn),
    .tick(rise[P_OSC_IF]),
    .div_val(r_div(q.if_r)),
    .pulse(if_comparison_reference)
  );

  plld_div #(.W(19)) u_rf_fb (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .clr(rf_pwr_dn),
    .tick(rise[P_RF_VCO]),
    .div_val(rf_div_val),
    .pulse(rf_feedback_divided)
  );

  plld_div #(.W(15)) u_if_fb (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .clr(if_pwr_dn),
    .tick(rise[P_IF_VCO]),
    .div_val(if_div_val),
    .pulse(if_feedback_divided)
  );

  assign ref_path_select = q.if_r[`PLLD_REF_SEL_BIT];
  assign rf_frac_carry = q.carry;
  assign cfg_invalid = q.invalid;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_shared_ref: assert property (q.if_r[`PLLD_REF_SEL_BIT] |-> rf_r_tick == rise[P_OSC_IF])
    else $error("shared mode RF reference not fed from IF oscillator");
  a_shift_in: assert property (clk_en && rise[P_SCLK] |=> q.shift == {$past(q.shift[22:0]), $past(q.lvl[P_SDATA])})
    else $error("serial bit not shifted in at LSB");
  a_latch_rfn: assert property (clk_en && rise[P_LE] && q.shift[1:0] == `PLLD_ADDR_RF_N |=> q.rf_n == $past(q.shift))
    else $error("RF N latch not loaded on strobe");
  a_le_filter: assert property (rise[P_LE] |-> q.s2[P_LE] && q.s3[P_LE] && !q.lvl[P_LE])
    else $error("strobe edge taken before stages agree");
  a_int_div: assert property (!frac_en |-> rf_div_val == {rf_int, q.rf_n[`PLLD_FRAC_MSB:`PLLD_FRAC_LSB]})
    else $error("integer mode divide value wrong");
  a_frac_div: assert property (frac_en |-> rf_div_val == 19'(rf_int) + 19'(q.carry))
    else $error("fractional divide value wrong");
  a_acc_carry: assert property (clk_en && frac_en && rf_feedback_divided && !rf_pwr_dn |=> q.carry == ($past(acc_sum) >= $past(acc_mod)))
    else $error("accumulator overflow not carried");
  a_pwrdn_clear: assert property (clk_en && rf_pwr_dn |=> q.acc == 4'h0 && !q.carry)
    else $error("power down left accumulator set");
  a_c_min: assert property (clk_en && q.rf_n[`PLLD_RF_C_MSB:`PLLD_RF_C_LSB] < `PLLD_RF_C_MIN |=> q.invalid)
    else $error("C below minimum not flagged");

  c_frac_swallow: cover property (rf_feedback_divided && frac_en ##1 q.carry);
  c_shared_ref: cover property (q.if_r[`PLLD_REF_SEL_BIT] && rf_comparison_reference);
  c_latch_ifn: cover property (rise[P_LE] && q.shift[1:0] == `PLLD_ADDR_IF_N);
endmodule : plld_dividers
`default_nettype wire

/* dv/plld_host_model.sv */
// Serial host model that shifts words MSB first and strobes the latch
`timescale 1ns/10ps
`default_nettype none
module plld_host_model (
  input wire logic core_clk,
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // Every clock, strobe and data-bit level is held at least four core cycles so the pin synchronisers see it
  task automatic send(input logic [23:0] word);
    int i;
    for (i = 23; i >= 0; i--) begin
      @(negedge core_clk);
      ser_data = word[i];
      repeat (4) @(negedge core_clk);
      ser_clk = 1'b1;
      repeat (4) @(negedge core_clk);
      ser_clk = 1'b0;
      // Hold time over: the line no longer shows the bit
      ser_data = ~word[i];
    end
    repeat (4) @(negedge core_clk);
    latch_strobe = 1'b1;
    repeat (4) @(negedge core_clk);
    latch_strobe = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask : send
endmodule : plld_host_model
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking testbench of the divider block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk, sys_rst, rf_pwr_dn, if_pwr_dn;
  logic [3:0] pin_q;
  logic [31:0] seed;
  wire logic ser_clk, ser_data, latch_strobe, ref_path_select, rf_frac_carry, cfg_invalid;
  wire logic [3:0] pulse;
  int errors, total_checks, k, r, b, a, fr, t, f;

  plld_host_model plld_host_model_inst (.core_clk(core_clk), .ser_clk(ser_clk),
    .ser_data(ser_data), .latch_strobe(latch_strobe));

  plld_dividers plld_dividers_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(latch_strobe),
    .osc_if_in(pin_q[0]), .osc_rf_in(pin_q[1]), .rf_vco_in(pin_q[2]), .if_vco_in(pin_q[3]),
    .rf_pwr_dn(rf_pwr_dn), .if_pwr_dn(if_pwr_dn), .rf_comparison_reference(pulse[0]),
    .rf_feedback_divided(pulse[1]), .if_comparison_reference(pulse[2]),
    .if_feedback_divided(pulse[3]), .ref_path_select(ref_path_select),
    .rf_frac_carry(rf_frac_carry), .cfg_invalid(cfg_invalid));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic int rnd(input int lo, input int hi);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return lo + int'(seed % (hi - lo + 1));
  endfunction : rnd

  function automatic logic [23:0] r_word(input bit sel, input int rv, input int adr);
    return {sel, 6'h00, 15'(rv), 2'(adr)};
  endfunction : r_word

  function automatic logic [23:0] n_word(input int c, input int bv, input int av, input int fv,
    input bit fen, input bit m15);
    return {1'b0, m15, fen, 11'(c), 2'(bv), 2'(av), 4'(fv), 2'h1};
  endfunction : n_word

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // Clears the counter by power down, then toggles one pin and counts ticks to the first pulse and over the next np periods
  task automatic measure(input int pin, input int pul, input int np, output int tk,
    output int first);
    int i, seen;
    seen = 0;
    tk = 0;
    first = 0;
    if (pul < 2) rf_pwr_dn = 1'b1;
    else if_pwr_dn = 1'b1;
    repeat (2) @(negedge core_clk);
    rf_pwr_dn = 1'b0;
    if_pwr_dn = 1'b0;
    for (i = 0; i < 40000 && seen <= np; i++) begin
      @(negedge core_clk);
      if (i % 8 == 0) begin
        pin_q[pin] = 1'b1;
        tk++;
      end
      if (i % 8 == 4) pin_q[pin] = 1'b0;
      if (pulse[pul] === 1'b1) begin
        seen++;
        if (seen == 1) begin
          first = tk;
          tk = 0;
        end
      end
    end
    pin_q[pin] = 1'b0;
    if (seen <= np) begin
      errors++;
      $display("unexpected pulse count expected %0d seen %0d", np + 1, seen);
      print_verdict();
    end
  endtask : measure

  initial begin
    errors = 0;
    total_checks = 0;
    seed = 32'h688484D5;
    sys_rst = 1'b1;
    rf_pwr_dn = 1'b0;
    if_pwr_dn = 1'b0;
    pin_q = 4'h0;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check("path_select", 0, ref_path_select);
    check("cfg_invalid", 0, cfg_invalid);
    for (k = 0; k < 3; k++) begin
      r = (k == 0) ? 3 : rnd(4, 40);
      plld_host_model_inst.send(r_word(1'b0, r, 0));
      measure(1, 0, 2, t, f);
      check("rf_ref_ticks", 2 * r, t);
      check("first_pulse", 1, f);
    end
    plld_host_model_inst.send(r_word(1'b0, 2, 0));
    check("cfg_invalid", 1, cfg_invalid);
    plld_host_model_inst.send(r_word(1'b0, 3, 0));
    r = rnd(3, 30);
    plld_host_model_inst.send(r_word(1'b1, r, 2));
    check("path_select", 1, ref_path_select);
    measure(0, 0, 1, t, f);
    // The RF reference counter keeps its own divide value of 3 while fed from the IF input
    check("shared_rf_ticks", 3, t);
    measure(0, 2, 1, t, f);
    check("if_ref_ticks", r, t);
    plld_host_model_inst.send(r_word(1'b0, 10, 2));
    b = rnd(7, 12);
    a = rnd(0, 7);
    plld_host_model_inst.send({7'h00, 12'(b), 3'(a), 2'h3});
    measure(3, 3, 1, t, f);
    check("if_fb_ticks", 8 * b + a, t);
    plld_host_model_inst.send({7'h00, 12'h006, 3'h7, 2'h3});
    check("cfg_invalid", 1, cfg_invalid);
    plld_host_model_inst.send({7'h00, 12'h007, 3'h0, 2'h3});
    for (k = 0; k < 2; k++) begin
      b = (k == 1) ? rnd(2, 3) : rnd(0, 1);
      a = rnd(0, 3);
      fr = rnd(0, 15);
      plld_host_model_inst.send(n_word(3, b, a, fr, 1'b0, 1'b0));
      measure(2, 1, 1, t, f);
      check("rf_int_ticks", ((8 + 8 * k) * 3 + 4 * b + a) * 16 + fr, t);
    end
    plld_host_model_inst.send(n_word(2, 0, 0, 0, 1'b0, 1'b0));
    check("cfg_invalid", 1, cfg_invalid);
    for (k = 0; k < 2; k++) begin
      fr = rnd(1, 14);
      plld_host_model_inst.send(n_word(5, 0, 0, fr, 1'b1, k[0]));
      check("cfg_invalid", 0, cfg_invalid);
      measure(2, 1, 16 - k, t, f);
      // A carry swallows in the period after its overflow, so one modulus window lags by one
      check("rf_frac_ticks", (16 - k) * 40 + fr - 1, t);
    end
    plld_host_model_inst.send(n_word(4, 0, 0, 3, 1'b1, 1'b0));
    check("cfg_invalid", 1, cfg_invalid);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
